// ### bench/fcs_drive_model.sv
// Drive-side partner model answering sector and identifier requests
`timescale 1ns/1ps
module fcs_drive_model (
    input wire logic mclk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic slow, // Long sector time when high
    input wire fcs_pkg::fcs_drive_t drive_ctl, // Request from sequencer
    output logic sector_done, // One pulse per sector
    output logic id_valid, // One pulse per identifier
    output fcs_pkg::fcs_id_t id_found, // Identifier on disk
    output logic [7:0] done_cnt // Sectors handed over so far
);
    import fcs_pkg::*;
    localparam fcs_id_t DISK_ID = {8'h07, 8'h01, 8'h09, 8'h02}; // Identifier recorded on the track
    logic [7:0] wait_r; // Cycles spent on the current sector
    // Identifier only meaningful with its pulse; otherwise show a changed pattern
    assign id_valid = sector_done;
    assign id_found = sector_done ? DISK_ID : ~DISK_ID;
    // Sector timer: a short or long spin per sector while requested
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wait_r <= 8'h00;
            done_cnt <= 8'h00;
            sector_done <= 1'b0;
        end
        else
        begin
            sector_done <= 1'b0;
            // Restart the spin after each sector so pulses never run together
            if (!drive_ctl.req || sector_done)
                wait_r <= 8'h00;
            else if (wait_r == (slow ? 8'h28 : 8'h02))
            begin
                sector_done <= 1'b1;
                done_cnt <= done_cnt + 8'h01;
            end
            else
                wait_r <= wait_r + 8'h01;
        end
    end
endmodule : fcs_drive_model

// ### bench/floppy_command_sequencer_test.sv
// Self-checking testbench for the floppy command sequencer
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module floppy_command_sequencer_test;
    import fcs_pkg::*;
    logic mclk = 1'b0; // 10 MHz clock
    logic rst = 1'b1; // Reset, held at start
    logic sel = 1'b0; // Register select
    logic host_rd = 1'b0; // Read strobe
    logic host_wr = 1'b0; // Write strobe
    logic [7:0] host_wdata = 8'h00; // Write data
    logic [1:0] rate_sel = 2'h0; // Rate choice
    logic pio_opt = 1'b0; // Programmed transfer option
    logic slow = 1'b0; // Slow drive answers
    logic del_mark = 1'b0; // Deleted mark seen by the drive
    logic [7:0] host_rdata; // Read data
    logic sector_done, id_valid; // Drive pulses
    fcs_id_t id_found; // Identifier from drive
    fcs_clk_en_t clk_en; // Derived clock enables
    fcs_drive_t drive_ctl; // Drive request
    logic double_density_select, dma_req, pio_req; // Mode and request levels
    logic [7:0] byte_count, gap3_length, head_load_delay, head_unload_delay, done_cnt; // Settings out
    logic [1:0] compare_stride; // Stride out
    logic [4:0] step_interval; // Step time out
    fcs_phase_t phase; // Current phase
    int err_total = 0; // Mismatches
    int checked = 0; // Comparisons
    logic [7:0] rb; // Last byte read

    fcs_seq dut_u (.mclk(mclk), .rst(rst), .register_select_line(sel), .host_rd(host_rd), .host_wr(host_wr),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .rate_sel(rate_sel),
        .programmed_transfer_option(pio_opt), .deleted_mark_seen(del_mark), .sector_done(sector_done),
        .id_valid(id_valid), .id_found(id_found), .drive_state_status(8'h20), .clk_en(clk_en),
        .drive_ctl(drive_ctl), .double_density_select(double_density_select), .dma_req(dma_req),
        .pio_req(pio_req), .byte_count(byte_count), .gap3_length(gap3_length), .compare_stride(compare_stride),
        .head_load_delay(head_load_delay), .head_unload_delay(head_unload_delay),
        .step_interval(step_interval), .phase(phase));

    fcs_drive_model drive_u (.mclk(mclk), .rst(rst), .slow(slow), .drive_ctl(drive_ctl),
        .sector_done(sector_done), .id_valid(id_valid), .id_found(id_found), .done_cnt(done_cnt));

    // Free-running clock
    initial
    begin
        forever #50 mclk = ~mclk;
    end

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic report_and_stop;
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // One strobed write; strobe dropped on the next edge
    task automatic wr(input logic s, input logic [7:0] d);
        @(posedge mclk);
        sel <= s;
        host_wr <= 1'b1;
        host_wdata <= d;
        @(posedge mclk);
        host_wr <= 1'b0;
    endtask : wr

    // One strobed read; data is loaded on the strobe's edge
    task automatic rd(input logic s);
        @(posedge mclk);
        sel <= s;
        host_rd <= 1'b1;
        @(posedge mclk);
        host_rd <= 1'b0;
        #1;
        rb = host_rdata;
    endtask : rd

    // Bounded wait for a phase, then confirm it
    task automatic wait_phase(input fcs_phase_t p);
        int n;
        n = 0;
        while (phase !== p && n < 3000)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(8'(phase), 8'(p));
    endtask : wait_phase

    // Reset values and status register selection
    task automatic t_reset;
        check(8'(phase), 8'(fcs_cmd));
        check(host_rdata, 8'h00);
        check(head_load_delay, 8'h02);
        check(head_unload_delay, 8'h10);
        check(8'(step_interval), 8'h01);
        rd(1'b0);
        check({6'h00, rb[`FCS_MSR_RQM], rb[`FCS_MSR_DIO]}, 8'h02);
    endtask : t_reset

    // Head load and unload delays at their upper bounds, step interval 4 ms
    task automatic t_specify;
        wr(1'b1, {3'h0, `FCS_OP_SPECIFY});
        wr(1'b1, 8'h3e);
        wr(1'b1, 8'hfe);
        repeat (3) @(posedge mclk);
        #1;
        check(head_load_delay, 8'hfe);
        check(head_unload_delay, 8'hf0);
        check(8'(step_interval), 8'h04);
        check(8'(phase), 8'(fcs_cmd));
    endtask : t_specify

    // Sector transfer from sector 1 to last sector 3, then seven results
    task automatic t_xfer(input logic [4:0] op, input logic mf, input logic [7:0] n, input logic [7:0] short_sector_byte_count);
        logic [7:0] base;
        base = done_cnt;
        wr(1'b1, {1'b0, mf, op == `FCS_OP_READ, op});
        wr(1'b1, 8'h01);
        wr(1'b1, 8'h05);
        wr(1'b1, 8'h00);
        wr(1'b1, 8'h01);
        wr(1'b1, n);
        wr(1'b1, 8'h03);
        wr(1'b1, 8'h1b);
        wr(1'b1, short_sector_byte_count);
        wait_phase(fcs_exec);
        check({7'h00, double_density_select}, {7'h00, mf});
        check(gap3_length, 8'h1b);
        check({6'h00, dma_req, pio_req}, {6'h00, !pio_opt, pio_opt});
        check({6'h00, drive_ctl.drive}, 8'h01);
        if (n == 8'h00)
            check(byte_count, short_sector_byte_count);
        if (op == `FCS_OP_READ)
        begin
            @(posedge mclk);
            del_mark <= 1'b1;
            @(posedge mclk);
            #1;
            check({6'h00, dma_req, pio_req}, 8'h00);
            @(posedge mclk);
            del_mark <= 1'b0;
        end
        wait_phase(fcs_result);
        check(done_cnt - base, 8'h03);
        rd(1'b0);
        check({7'h00, rb[`FCS_MSR_DIO]}, 8'h01);
        rd(1'b1);
        check(rb, 8'h01);
        rd(1'b1);
        check(rb, 8'h00);
        rd(1'b1);
        check(rb, 8'h00);
        rd(1'b1);
        check(rb, 8'h05);
        rd(1'b1);
        rd(1'b1);
        check(rb, 8'h03);
        rd(1'b1);
        check(rb, n);
        wait_phase(fcs_cmd);
    endtask : t_xfer

    // Identifier read on head one returns what the drive found
    task automatic t_rdid;
        wr(1'b1, {3'h2, `FCS_OP_RDID});
        wr(1'b1, 8'h04);
        wait_phase(fcs_exec);
        check({7'h00, drive_ctl.head}, 8'h01);
        wait_phase(fcs_result);
        repeat (3) rd(1'b1);
        rd(1'b1);
        check(rb, 8'h07);
        rd(1'b1);
        check(rb, 8'h01);
        rd(1'b1);
        check(rb, 8'h09);
        rd(1'b1);
        check(rb, 8'h02);
        wait_phase(fcs_cmd);
    endtask : t_rdid

    // Enable pulse counts over 160 cycles, one count of slack for phase
    task automatic t_rate(input logic [1:0] r, input int es, input int em, input int ew);
        int s, m, w;
        s = 0;
        m = 0;
        w = 0;
        @(posedge mclk);
        rate_sel <= r;
        repeat (20) @(posedge mclk);
        repeat (160)
        begin
            @(posedge mclk);
            #1;
            s += int'(clk_en.sclk_en);
            m += int'(clk_en.mclk_en);
            w += int'(clk_en.wclk_en);
        end
        check(8'(s >= es - 1 && s <= es + 1), 8'h01);
        check(8'(m >= em - 1 && m <= em + 1), 8'h01);
        check(8'(w >= ew - 1 && w <= ew + 1), 8'h01);
    endtask : t_rate

    // Watchdog sized well beyond the expected run
    initial
    begin
        #3000000;
        err_total++;
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        t_reset();
        t_specify();
        t_xfer(`FCS_OP_READ, 1'b1, 8'h02, 8'hff);
        pio_opt <= 1'b1;
        slow <= 1'b1;
        t_xfer(`FCS_OP_WRITE, 1'b0, 8'h00, 8'h80);
        pio_opt <= 1'b0;
        slow <= 1'b0;
        t_xfer(`FCS_OP_WRDEL, 1'b1, 8'h00, 8'h40);
        t_rdid();
        t_rate(`FCS_RATE_500, 160, 40, 10);
        t_rate(`FCS_RATE_250, 80, 20, 5);
        t_rate(`FCS_RATE_300, 96, 24, 6);
        report_and_stop();
    end
endmodule : floppy_command_sequencer_test

// ### logic/fcs_cfg.svh
// Constants for the floppy command sequencer
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
`define FCS_OP_READ 5'h06
`define FCS_OP_WRITE 5'h05
`define FCS_OP_WRDEL 5'h09
`define FCS_OP_RDDEL 5'h0c
`define FCS_OP_RDID 5'h0a
`define FCS_OP_RDTRK 5'h02
`define FCS_OP_FORMAT 5'h0d
`define FCS_OP_SCANEQ 5'h11
`define FCS_OP_SCANLE 5'h19
`define FCS_OP_SCANHE 5'h1d
`define FCS_OP_RECAL 5'h07
`define FCS_OP_SENSEI 5'h08
`define FCS_OP_SPECIFY 5'h03
`define FCS_OP_SENSED 5'h04
`define FCS_OP_SEEK 5'h0f
`define FCS_LEN_RW 4'h9
`define FCS_LEN_TWO 4'h2
`define FCS_LEN_FMT 4'h6
`define FCS_LEN_SPEC 4'h3
`define FCS_LEN_ONE 4'h1
`define FCS_RES_SEVEN 3'h7
`define FCS_RES_TWO 3'h2
`define FCS_RES_ONE 3'h1
`define FCS_RES_NONE 3'h0
`define FCS_BIT_MT 7
`define FCS_BIT_MF 6
`define FCS_BIT_SK 5
`define FCS_IDX_C 4'h2
`define FCS_IDX_H 4'h3
`define FCS_IDX_R 4'h4
`define FCS_IDX_N 4'h5
`define FCS_IDX_EOT 4'h6
`define FCS_IDX_GPL 4'h7
`define FCS_IDX_LAST 4'h8
`define FCS_MSR_RQM 7
`define FCS_MSR_DIO 6
`define FCS_MSR_BUSY 4
`define FCS_HLT_STEP_MS 2
`define FCS_HUT_STEP_MS 16
`define FCS_SRT_STEP_MS 1
`define FCS_RATE_500 2'h0
`define FCS_RATE_300 2'h1
`define FCS_RATE_250 2'h2
`define FCS_CLK_MHZ 10
`define FCS_SRC_MHZ 16
`endif

// ### logic/fcs_pkg.sv
// Types shared by the floppy command sequencer files
package fcs_pkg;
    typedef enum logic [1:0] {fcs_cmd, fcs_exec, fcs_result} fcs_phase_t;
    typedef struct packed {
        logic sclk_en; // Sampling clock enable
        logic mclk_en; // Master clock enable
        logic wclk_en; // Write clock enable
    } fcs_clk_en_t;
    typedef struct packed {
        logic [7:0] cyl; // Cylinder
        logic [7:0] head; // Head address
        logic [7:0] sector; // Sector number
        logic [7:0] size; // Size code
    } fcs_id_t;
    typedef struct packed {
        logic req; // Drive transfer request
        logic [7:0] sector; // Sector being worked
        logic [1:0] drive; // Selected drive
        logic head; // Selected head
    } fcs_drive_t;
endpackage : fcs_pkg

// ### logic/fcs_rate_div.sv
// Rate enable divider for one derived clock
`timescale 1ns/1ps
module fcs_rate_div #(
    parameter int NUM = 16, // Target rate numerator in 100 kHz
    parameter int DEN = 100 // Source rate in 100 kHz
) (
    input wire logic mclk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic [7:0] rate_num, // Requested rate in 100 kHz
    output logic tick // One-cycle enable pulse
);
    // Phase accumulator; fractional rates jitter by one cycle, the average is exact
    logic [15:0] acc_r;
    logic [15:0] acc_nxt;
    logic tick_nxt;
    always_comb
    begin
        acc_nxt = acc_r + {8'h00, rate_num};
        tick_nxt = 1'b0;
        if (acc_nxt >= 16'(DEN))
        begin
            acc_nxt = acc_nxt - 16'(DEN);
            tick_nxt = 1'b1;
        end
    end
    // Register stage
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            acc_r <= 16'h0000;
            tick <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            tick <= tick_nxt;
        end
    end
    // Accumulator must stay below the source rate or ticks would be lost
    property p_acc_below_den; @(posedge mclk) disable iff (rst) acc_r < 16'(DEN); endproperty
    a_acc_below_den: assert property (p_acc_below_den) else $error("Rate accumulator out of range");
    // No enable pulse straight out of reset
    property p_tick_reset; @(posedge mclk) rst |=> !tick; endproperty
    a_tick_reset: assert property (p_tick_reset) else $error("Enable pulse after reset");
endmodule : fcs_rate_div

// ### logic/fcs_seq.sv
// Floppy command sequencer: command, execution and result phases
//
// Overview of operation
// - 500k MFM: sample 16, master 4, write 1 MHz
// - fifteen operations, started by data writes of one to nine bytes
// - phases run command, execution, then result
// - result bytes offered after execution completes
// - select line low status, high data
// - transfer stops after sector equal last_sector_number
// - short count used only when size zero
// - head load delay 0-254 ms, 2 ms steps
// - head unload delay 0-240 ms, 16 ms steps
// - step interval 1-16 ms, 1 ms steps
// - density bit low FM, high MFM
// - multitrack continues onto second head
// - compare stride one consecutive, two alternate
// - bypass flag skips deleted-mark sectors
// - gap3 length sets format gap size
// - programmed option moves data without DMA
// - read sector: nine bytes in, seven out
// - write sector: same bytes, bypass zero
// - deleted write: nine in, seven out
// - identifier read returns first found identifier
// - track read runs index to last sector
// - format takes four parameters, returns seven
// - equal compare adds stride parameter
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module fcs_seq (
    input wire logic mclk, // 10 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic register_select_line, // Low status, high data
    input wire logic host_rd, // Host read strobe
    input wire logic host_wr, // Host write strobe
    input wire logic [7:0] host_wdata, // Host write data
    output logic [7:0] host_rdata, // Host read data
    input wire logic [1:0] rate_sel, // Data rate choice
    input wire logic programmed_transfer_option, // Non-DMA transfers
    input wire logic deleted_mark_seen, // Current sector has deleted mark
    input wire logic sector_done, // Drive finished one sector
    input wire logic id_valid, // Drive found a good identifier
    input wire fcs_pkg::fcs_id_t id_found, // Identifier seen on disk
    input wire logic [7:0] drive_state_status, // Drive status byte
    output fcs_pkg::fcs_clk_en_t clk_en, // Derived clock enables
    output fcs_pkg::fcs_drive_t drive_ctl, // Drive request and selection
    output logic double_density_select, // High selects MFM
    output logic dma_req, // DMA data request
    output logic pio_req, // Programmed transfer request
    output logic [7:0] byte_count, // Bytes per sector
    output logic [7:0] gap3_length, // Gap 3 size
    output logic [1:0] compare_stride, // Compare stride
    output logic [7:0] head_load_delay, // Head load time in ms
    output logic [7:0] head_unload_delay, // Head unload time in ms
    output logic [4:0] step_interval, // Step time in ms
    output fcs_pkg::fcs_phase_t phase // Current phase
);
    import fcs_pkg::*;

    // Rate numerators in 100 kHz units for sample, master and write clocks
    logic [7:0] s_num;
    logic [7:0] m_num;
    logic [7:0] w_num;
    always_comb
    begin
        case (rate_sel)
            `FCS_RATE_500:
            begin
                s_num = 8'ha0;
                m_num = 8'h28;
                w_num = 8'h0a;
            end
            `FCS_RATE_300:
            begin
                s_num = 8'h60;
                m_num = 8'h18;
                w_num = 8'h06;
            end
            default:
            begin
                // 250k MFM scales every clock by half
                s_num = 8'h50;
                m_num = 8'h14;
                w_num = 8'h05;
            end
        endcase
    end
    // Enables stand for the scaled clocks; the fastest cannot exceed mclk, so
    // the sampling rate is scaled down by the source-to-mclk ratio
    fcs_rate_div #(.NUM(1), .DEN(`FCS_SRC_MHZ * 10)) u_sdiv (
        .mclk(mclk), .rst(rst), .rate_num(s_num), .tick(clk_en.sclk_en));
    fcs_rate_div #(.NUM(1), .DEN(`FCS_SRC_MHZ * 10)) u_mdiv (
        .mclk(mclk), .rst(rst), .rate_num(m_num), .tick(clk_en.mclk_en));
    fcs_rate_div #(.NUM(1), .DEN(`FCS_SRC_MHZ * 10)) u_wdiv (
        .mclk(mclk), .rst(rst), .rate_num(w_num), .tick(clk_en.wclk_en));

    // Parameter bytes gathered during the command phase
    logic [7:0] pbuf_r [0:8];
    logic [7:0] pbuf_nxt [0:8];
    logic [3:0] idx_r, idx_nxt; // Byte position in phase
    logic [3:0] need_r, need_nxt; // Command length
    logic [2:0] rlen_r, rlen_nxt; // Result length
    fcs_phase_t phase_r, phase_nxt;
    logic [7:0] sec_r, sec_nxt; // Working sector
    logic head_r, head_nxt; // Working head
    logic [7:0] st0_r, st0_nxt; // result_status_a
    logic [7:0] hlt_r, hlt_nxt, hut_r, hut_nxt;
    logic [4:0] srt_r, srt_nxt;
    fcs_id_t idcap_r, idcap_nxt; // Captured identifier
    logic [4:0] op;
    logic [7:0] res_byte;
    logic last_sec;

    assign op = pbuf_r[0][4:0];
    assign last_sec = (sec_r == pbuf_r[`FCS_IDX_EOT]);

    // Command length and result length by opening byte
    function automatic logic [6:0] fcs_lens(input logic [4:0] code);
        begin
            case (code)
                `FCS_OP_READ, `FCS_OP_WRITE, `FCS_OP_WRDEL, `FCS_OP_RDDEL, `FCS_OP_RDTRK,
                `FCS_OP_SCANEQ, `FCS_OP_SCANLE, `FCS_OP_SCANHE:
                    fcs_lens = {`FCS_LEN_RW, `FCS_RES_SEVEN};
                `FCS_OP_RDID: fcs_lens = {`FCS_LEN_TWO, `FCS_RES_SEVEN};
                // four parameters plus two code bytes
                `FCS_OP_FORMAT: fcs_lens = {`FCS_LEN_FMT, `FCS_RES_SEVEN};
                `FCS_OP_SPECIFY: fcs_lens = {`FCS_LEN_SPEC, `FCS_RES_NONE};
                `FCS_OP_SEEK: fcs_lens = {`FCS_LEN_SPEC, `FCS_RES_NONE};
                `FCS_OP_RECAL: fcs_lens = {`FCS_LEN_TWO, `FCS_RES_NONE};
                `FCS_OP_SENSED: fcs_lens = {`FCS_LEN_TWO, `FCS_RES_ONE};
                `FCS_OP_SENSEI: fcs_lens = {`FCS_LEN_ONE, `FCS_RES_TWO};
                // Unknown codes answer one status byte
                default: fcs_lens = {`FCS_LEN_ONE, `FCS_RES_ONE};
            endcase
        end
    endfunction : fcs_lens

    // Result byte mux, seven-byte layout: three status, then identifier
    always_comb
    begin
        case (idx_r)
            4'h0: res_byte = (rlen_r == `FCS_RES_ONE && op == `FCS_OP_SENSED) ? drive_state_status : st0_r;
            4'h1: res_byte = (rlen_r == `FCS_RES_TWO) ? idcap_r.cyl : 8'h00;
            4'h2: res_byte = 8'h00;
            4'h3: res_byte = idcap_r.cyl;
            4'h4: res_byte = idcap_r.head;
            4'h5: res_byte = idcap_r.sector;
            4'h6: res_byte = idcap_r.size;
            default: res_byte = 8'h00;
        endcase
    end

    // Sequencer next-state logic
    always_comb
    begin
        pbuf_nxt = pbuf_r;
        idx_nxt = idx_r;
        need_nxt = need_r;
        rlen_nxt = rlen_r;
        phase_nxt = phase_r;
        sec_nxt = sec_r;
        head_nxt = head_r;
        st0_nxt = st0_r;
        hlt_nxt = hlt_r;
        hut_nxt = hut_r;
        srt_nxt = srt_r;
        idcap_nxt = idcap_r;
        case (phase_r)
            fcs_cmd:
            begin
                if (host_wr && register_select_line)
                begin
                    pbuf_nxt[idx_r] = host_wdata;
                    if (idx_r == 4'h0)
                        {need_nxt, rlen_nxt} = fcs_lens(host_wdata[4:0]);
                    idx_nxt = idx_r + 4'h1;
                    if ((idx_r + 4'h1) >= ((idx_r == 4'h0) ? fcs_lens(host_wdata[4:0]) >> 3 : {3'h0, need_r}))
                    begin
                        idx_nxt = 4'h0;
                        phase_nxt = fcs_exec;
                    end
                end
            end
            fcs_exec:
            begin
                case (op)
                    `FCS_OP_SPECIFY:
                    begin
                        srt_nxt = 5'(pbuf_r[1][7:4]) + 5'h01;
                        hut_nxt = {pbuf_r[1][3:0] + 4'h1, 4'h0};
                        hlt_nxt = {pbuf_r[2][7:1], 1'b0};
                        phase_nxt = fcs_cmd;
                    end
                    `FCS_OP_SEEK, `FCS_OP_RECAL:
                        phase_nxt = fcs_cmd;
                    `FCS_OP_SENSED, `FCS_OP_SENSEI:
                        phase_nxt = fcs_result;
                    `FCS_OP_RDID:
                    begin
                        if (id_valid)
                        begin
                            idcap_nxt = id_found;
                            phase_nxt = fcs_result;
                        end
                    end
                    `FCS_OP_FORMAT:
                    begin
                        // one pass over the track; gap from parameter
                        if (sector_done)
                        begin
                            sec_nxt = sec_r + 8'h01;
                            idcap_nxt.sector = sec_r + 8'h01;
                            if (sec_r + 8'h01 >= pbuf_r[3])
                                phase_nxt = fcs_result;
                        end
                    end
                    default:
                    begin
                        if (sector_done)
                        begin
                            idcap_nxt = {pbuf_r[`FCS_IDX_C], 7'h00, head_r, sec_r, pbuf_r[`FCS_IDX_N]};
                            // end of track, maybe other head
                            if (last_sec && pbuf_r[0][`FCS_BIT_MT] && !head_r && op != `FCS_OP_RDTRK)
                            begin
                                head_nxt = 1'b1;
                                sec_nxt = 8'h01;
                            end
                            else if (last_sec)
                                phase_nxt = fcs_result;
                            else if (op[4] && pbuf_r[`FCS_IDX_LAST][1])
                                sec_nxt = sec_r + 8'h02;
                            else
                                sec_nxt = sec_r + 8'h01;
                        end
                    end
                endcase
                if (phase_nxt == fcs_result)
                    st0_nxt = {6'h00, pbuf_r[1][1:0]} | {5'h00, head_r, 2'h0};
            end
            fcs_result:
            begin
                if (host_rd && register_select_line)
                begin
                    idx_nxt = idx_r + 4'h1;
                    if (idx_r + 4'h1 >= {1'b0, rlen_r})
                    begin
                        idx_nxt = 4'h0;
                        phase_nxt = fcs_cmd;
                    end
                end
            end
            default: phase_nxt = fcs_cmd;
        endcase
        // Entering execution loads working sector and head
        if (phase_r == fcs_cmd && phase_nxt == fcs_exec)
        begin
            sec_nxt = (op == `FCS_OP_RDTRK || op == `FCS_OP_FORMAT) ? 8'h00 : pbuf_nxt[`FCS_IDX_R];
            if (pbuf_nxt[0][4:0] == `FCS_OP_RDTRK)
                sec_nxt = 8'h01;
            if (pbuf_nxt[0][4:0] == `FCS_OP_FORMAT)
                sec_nxt = 8'h00;
            head_nxt = pbuf_nxt[1][2];
        end
    end

    // Sequencer registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 9; i++)
                pbuf_r[i] <= 8'h00;
            idx_r <= 4'h0;
            need_r <= 4'h0;
            rlen_r <= 3'h0;
            phase_r <= fcs_cmd;
            sec_r <= 8'h00;
            head_r <= 1'b0;
            st0_r <= 8'h00;
            hlt_r <= 8'h02;
            hut_r <= 8'h10;
            srt_r <= 5'h01;
            idcap_r <= '0;
        end
        else
        begin
            pbuf_r <= pbuf_nxt;
            idx_r <= idx_nxt;
            need_r <= need_nxt;
            rlen_r <= rlen_nxt;
            phase_r <= phase_nxt;
            sec_r <= sec_nxt;
            head_r <= head_nxt;
            st0_r <= st0_nxt;
            hlt_r <= hlt_nxt;
            hut_r <= hut_nxt;
            srt_r <= srt_nxt;
            idcap_r <= idcap_nxt;
        end
    end
    // Phases run in order; a command never jumps straight to results
    property p_cmd_no_skip; @(posedge mclk) disable iff (rst) phase_r == fcs_cmd |=> phase_r != fcs_result; endproperty
    a_cmd_no_skip: assert property (p_cmd_no_skip) else $error("Result phase entered from command phase");
    sequence s_exec_done; phase_r == fcs_exec ##1 phase_r == fcs_result; endsequence
    property p_result_start; @(posedge mclk) disable iff (rst) s_exec_done |-> idx_r == 4'h0; endproperty
    a_result_start: assert property (p_result_start) else $error("Results not offered from the first byte");
    // Status reads must not consume a result byte
    property p_stat_rd_holds;
        @(posedge mclk) disable iff (rst) (host_rd && !register_select_line && phase_r == fcs_result) |=> $stable(idx_r);
    endproperty
    a_stat_rd_holds: assert property (p_stat_rd_holds) else $error("Status read advanced the result index");

    // Data transfer operations need the drive's sector stream
    logic xfer_op;
    logic skip_sec;
    assign xfer_op = (phase_r == fcs_exec) && (op != `FCS_OP_SPECIFY) && (op != `FCS_OP_SEEK)
        && (op != `FCS_OP_RECAL) && (op != `FCS_OP_SENSED) && (op != `FCS_OP_SENSEI);
    // bypass deleted sectors on any operation with the bypass flag set
    assign skip_sec = pbuf_r[0][`FCS_BIT_SK] && deleted_mark_seen;
    assign pio_req = xfer_op && !skip_sec && programmed_transfer_option;
    assign dma_req = xfer_op && !skip_sec && !programmed_transfer_option;
    property p_skip_no_req; @(posedge mclk) disable iff (rst) (pbuf_r[0][`FCS_BIT_SK] && deleted_mark_seen) |-> !(dma_req || pio_req); endproperty
    a_skip_no_req: assert property (p_skip_no_req) else $error("Request raised for a bypassed sector");
    property p_pio_excl; @(posedge mclk) disable iff (rst) pio_req |-> (programmed_transfer_option && !dma_req); endproperty
    a_pio_excl: assert property (p_pio_excl) else $error("Programmed request without its option");

    // Status and data reads; selects the source
    logic [7:0] msr;
    assign msr = {phase_r != fcs_exec, phase_r == fcs_result, 1'b0, phase_r != fcs_cmd, 4'h0};
    always_ff @(posedge mclk)
    begin
        if (rst)
            host_rdata <= 8'h00;
        else if (host_rd)
            host_rdata <= register_select_line ? res_byte : msr;
    end

    // Outputs taken from registers
    assign phase = phase_r;
    assign double_density_select = pbuf_r[0][`FCS_BIT_MF];
    // short count only for size zero
    assign byte_count = (pbuf_r[`FCS_IDX_N] == 8'h00) ? pbuf_r[`FCS_IDX_LAST] : 8'hff;
    assign gap3_length = (op == `FCS_OP_FORMAT) ? pbuf_r[4] : pbuf_r[`FCS_IDX_GPL];
    assign compare_stride = pbuf_r[`FCS_IDX_LAST][1:0];
    assign head_load_delay = hlt_r;
    assign head_unload_delay = hut_r;
    assign step_interval = srt_r;
    assign drive_ctl = {xfer_op, sec_r, pbuf_r[1][1:0], head_r};
endmodule : fcs_seq
